// ### inc/conv_pkg.sv
/*
  Shared constants and types for the converter control block: register
  indices, field positions, reset values and timing counts.
  Assumes a 10 MHz system clock and a classic Wishbone register bus.
*/
package conv_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CMP_CTRL    = 4'h0;
  localparam logic [3:0] IDX_PIN_DISABLE = 4'h1;
  localparam logic [3:0] IDX_CTRL_A      = 4'h2;
  localparam logic [3:0] IDX_CTRL_B      = 4'h3;
  localparam logic [3:0] IDX_MUX_SEL     = 4'h4;
  localparam logic [3:0] IDX_RES_LOW     = 4'h5;
  localparam logic [3:0] IDX_RES_HIGH    = 4'h6;
  localparam logic [3:0] IDX_CPU_STATUS  = 4'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Comparator control/status
  localparam int CMP_OUT_BIT     = 5;
  localparam int CMP_FLAG_BIT    = 4;
  localparam int CMP_IE_BIT      = 3;
  localparam int CMP_CAPT_BIT    = 2;
  // Control A
  localparam int CA_ENABLE_BIT   = 7;
  localparam int CA_START_BIT    = 6;
  localparam int CA_AUTO_BIT     = 5;
  localparam int CA_DONE_BIT     = 4;
  // Control B
  localparam int CB_MUXEN_BIT    = 6;
  // Mux select
  localparam int MX_LEFT_BIT     = 5;
  // CPU status word
  localparam int GIE_BIT         = 7;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [3:0] CONV_CYCLES    = 4'hd;
  localparam logic [2:0] PRESCALE_LAST  = 3'h7;
  localparam logic [2:0] TRIG_FREE_RUN  = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMP_TOGGLE  = 2'h0,
    CMP_RESVD   = 2'h1,
    CMP_FALLING = 2'h2,
    CMP_RISING  = 2'h3
  } cmp_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_CONV = 2'h3
  } conv_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic [7:0]  cmp_ctrl;
    logic [7:0]  pin_disable;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  mux_sel;
    logic [7:0]  cpu_status;
    logic [7:0]  mux_active;
    logic [9:0]  result;
    logic        read_lock;
    conv_state_t state;
    logic [3:0]  conv_count;
    logic [2:0]  prescale;
    logic        cmp_meta;
    logic        cmp_sync;
    logic        cmp_prev;
    logic [7:0]  trig_meta;
    logic [7:0]  trig_sync;
    logic        trig_prev;
    logic [7:0]  port_meta;
    logic [7:0]  port_sync;
    logic        ack;
    logic [31:0] rdata;
    logic        cmp_irq;
    logic        capture_in;
    logic [3:0]  neg_sel;
    logic        conv_pulse;
    logic        sample_req;
  } conv_state_reg_t;

endpackage

// ### hdl/analog_conversion_control.sv
/*
  Control logic around an analog comparator and a 10-bit successive
  approximation converter, with a Wishbone classic register slave.
  Assumes the analog core hands back a 10-bit code on sample request,
  and that the comparator output and trigger lines are asynchronous.
*/
// Operation
// RULE_01 - Capture-route bit feeds comparator output to timer capture input, else none.
// RULE_02 - Comparator mode: 00 toggle, 01 reserved, 10 falling, 11 rising.
// RULE_03 - Software clears comparator interrupt enable before changing the mode.
// RULE_04 - Mux enable with converter off picks channel pin as negative input.
// RULE_05 - Input disable bit forces that pin's port read to zero; code gates only pins 0 and 1, pins 2 to 7 read through.
// RULE_06 - Conversion yields 10-bit unsigned code, ground minimum.
// RULE_07 - Reference and channel selections apply only while converter is enabled.
// RULE_08 - Result right-aligned by default, left-aligned when left adjust set.
// RULE_09 - Reading low byte locks result bytes until high byte is read.
// RULE_10 - Done flag still rises when a locked result is discarded.
// RULE_11 - Writing start begins conversion; start reads one until completion.
// RULE_12 - Channel change mid-conversion applies only after conversion ends.
// RULE_13 - Auto-trigger rising edge resets prescaler and starts conversion.
// RULE_14 - Trigger edges during conversion ignored; held level starts nothing.
// RULE_15 - Trigger flags set even when masked; software clears before next event.
// RULE_16 - Done flag as trigger runs free; first conversion needs start write.
// RULE_17 - Start write works under auto-trigger; start reads one in any conversion.
// RULE_18 - Comparator flag sets on event, clears on vector taken or write one.
// RULE_19 - Comparator status passes a two-stage synchroniser.
// RULE_20 - Conversion takes 13 converter clocks, then result and done flag update.
// RULE_21 - Comparator request only when its enable and global enable are set.
// RULE_22 - Left mode: bits 9..2 high byte, 1..0 top of low byte.
`timescale 1ns/1ps

module analog_conversion_control (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Register bus
  input  wire conv_pkg::wb_req_t wb_req,
  output logic                   wb_ack,
  output logic [31:0]            wb_dat_o,
  // Comparator and pins
  input  wire logic              cmp_raw_out,
  input  wire logic [7:0]        port_pins_in,
  output logic [7:0]             port_pins_read,
  output logic                   capture_route_out,
  output logic [3:0]             cmp_neg_select,
  output logic                   cmp_irq_req,
  input  wire logic              cmp_vector_taken,
  // Converter core and triggers
  input  wire logic [9:0]        analog_code,
  input  wire logic [7:0]        trigger_sources,
  output logic                   sample_request,
  output logic [7:0]             active_mux_select,
  output logic                   conv_done_pulse
);
  import conv_pkg::*;

  conv_state_reg_t r;
  conv_state_reg_t next_r;

  // ----------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------
  logic       wr;
  logic       rd;
  logic       cmp_event;
  logic       trig_level;
  logic       trig_edge;
  logic       start_req;
  logic       conv_end;
  logic       tick;
  logic [7:0] res_low;
  logic [7:0] res_high;
  logic [7:0] rd_byte;

  always_comb begin
    next_r = r;
    wr = wb_req.cyc && wb_req.stb && wb_req.we && !r.ack && wb_req.sel[0];
    rd = wb_req.cyc && wb_req.stb && !wb_req.we && !r.ack;

    // Synchronisers for asynchronous inputs
    next_r.cmp_meta  = cmp_raw_out;
    next_r.cmp_sync  = r.cmp_meta;                              // RULE_19
    next_r.cmp_prev  = r.cmp_sync;
    next_r.trig_meta = trigger_sources;
    next_r.trig_sync = r.trig_meta;
    next_r.port_meta = port_pins_in;
    next_r.port_sync = r.port_meta;

    // Comparator event selection
    unique case (cmp_mode_t'(r.cmp_ctrl[1:0]))
      CMP_TOGGLE:  cmp_event = r.cmp_sync ^ r.cmp_prev;         // RULE_02
      CMP_RESVD:   cmp_event = 1'b0;                            // RULE_02
      CMP_FALLING: cmp_event = r.cmp_prev & ~r.cmp_sync;        // RULE_02
      CMP_RISING:  cmp_event = r.cmp_sync & ~r.cmp_prev;        // RULE_02
    endcase
    next_r.cmp_ctrl[CMP_OUT_BIT] = r.cmp_sync;                  // RULE_19

    // Converter timing: prescaler tick every 8 system clocks
    tick = r.ctrl_a[CA_ENABLE_BIT] && (r.prescale == PRESCALE_LAST);
    next_r.prescale = r.ctrl_a[CA_ENABLE_BIT] ? r.prescale + 3'h1 : 3'h0;
    conv_end = (r.state == ST_CONV) && tick && (r.conv_count == CONV_CYCLES - 4'h1);

    // Trigger source selection; code 0 is the done flag for free running
    if (r.ctrl_b[2:0] == TRIG_FREE_RUN)
      trig_level = r.ctrl_a[CA_DONE_BIT];
    else
      trig_level = r.trig_sync[r.ctrl_b[2:0]];
    next_r.trig_prev = trig_level;
    trig_edge = trig_level && !r.trig_prev && (r.ctrl_b[2:0] != TRIG_FREE_RUN);

    // Result byte views
    if (r.mux_sel[MX_LEFT_BIT]) begin
      res_high = r.result[9:2];                                 // RULE_22
      res_low  = {r.result[1:0], 6'h00};                        // RULE_22
    end else begin
      res_high = {6'h00, r.result[9:8]};                        // RULE_08
      res_low  = r.result[7:0];                                 // RULE_08
    end

    // Bus read data
    unique case (wb_req.adr[5:2])
      IDX_CMP_CTRL:    rd_byte = r.cmp_ctrl;
      IDX_PIN_DISABLE: rd_byte = r.pin_disable;
      IDX_CTRL_A:      rd_byte = r.ctrl_a;
      IDX_CTRL_B:      rd_byte = r.ctrl_b;
      IDX_MUX_SEL:     rd_byte = r.mux_sel;
      IDX_RES_LOW:     rd_byte = res_low;
      IDX_RES_HIGH:    rd_byte = res_high;
      IDX_CPU_STATUS:  rd_byte = r.cpu_status;
      default:         rd_byte = 8'h00;
    endcase
    next_r.ack   = wb_req.cyc && wb_req.stb && !r.ack;
    next_r.rdata = rd ? {24'h000000, rd_byte} : 32'h00000000;

    // Result read lock
    if (rd && wb_req.adr[5:2] == IDX_RES_LOW)
      next_r.read_lock = 1'b1;                                  // RULE_09
    if (rd && wb_req.adr[5:2] == IDX_RES_HIGH)
      next_r.read_lock = 1'b0;                                  // RULE_09

    // Register writes
    start_req = 1'b0;
    if (wr) begin
      unique case (wb_req.adr[5:2])
        IDX_CMP_CTRL: begin
          next_r.cmp_ctrl[3:0] = wb_req.dat[3:0];
          if (wb_req.dat[CMP_FLAG_BIT])
            next_r.cmp_ctrl[CMP_FLAG_BIT] = 1'b0;               // RULE_18
        end
        IDX_PIN_DISABLE: next_r.pin_disable = wb_req.dat[7:0];
        IDX_CTRL_A: begin
          next_r.ctrl_a[7]   = wb_req.dat[7];
          next_r.ctrl_a[5]   = wb_req.dat[5];
          next_r.ctrl_a[3:0] = wb_req.dat[3:0];
          if (wb_req.dat[CA_DONE_BIT])
            next_r.ctrl_a[CA_DONE_BIT] = 1'b0;                  // RULE_15
          start_req = wb_req.dat[CA_START_BIT];                 // RULE_17
        end
        IDX_CTRL_B:     next_r.ctrl_b = wb_req.dat[7:0];
        IDX_MUX_SEL:    next_r.mux_sel = wb_req.dat[7:0];
        IDX_CPU_STATUS: next_r.cpu_status = wb_req.dat[7:0];
        default: ;
      endcase
    end
    if (cmp_vector_taken)
      next_r.cmp_ctrl[CMP_FLAG_BIT] = 1'b0;                     // RULE_18
    if (cmp_event)
      next_r.cmp_ctrl[CMP_FLAG_BIT] = 1'b1;                     // RULE_18

    // Selection follows the written value while enabled, except mid-conversion
    if (r.ctrl_a[CA_ENABLE_BIT] && (r.state != ST_CONV || conv_end))
      next_r.mux_active = r.mux_sel;                            // RULE_07 RULE_12

    // Conversion sequencer
    next_r.conv_pulse = 1'b0;
    next_r.sample_req = 1'b0;
    unique case (r.state)
      ST_IDLE: begin
        if (r.ctrl_a[CA_ENABLE_BIT] && start_req) begin
          next_r.ctrl_a[CA_START_BIT] = 1'b1;                   // RULE_11
          next_r.state = ST_WAIT;
        end else if (r.ctrl_a[CA_ENABLE_BIT] && r.ctrl_a[CA_AUTO_BIT] && trig_edge) begin
          next_r.ctrl_a[CA_START_BIT] = 1'b1;                   // RULE_17
          next_r.prescale = 3'h0;                               // RULE_13
          next_r.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tick) begin
          next_r.state = ST_CONV;
          next_r.conv_count = 4'h0;
          next_r.sample_req = 1'b1;
        end
      end
      ST_CONV: begin
        // Edges arriving here are ignored
        if (tick)
          next_r.conv_count = r.conv_count + 4'h1;              // RULE_20 RULE_14
        if (conv_end) begin
          next_r.ctrl_a[CA_DONE_BIT] = 1'b1;                    // RULE_10 RULE_20
          next_r.conv_pulse = 1'b1;
          if (!r.read_lock)
            next_r.result = analog_code;                        // RULE_06 RULE_09
          if (r.ctrl_a[CA_AUTO_BIT] && r.ctrl_b[2:0] == TRIG_FREE_RUN) begin
            next_r.state = ST_CONV;                             // RULE_16
            next_r.conv_count = 4'h0;
            next_r.sample_req = 1'b1;
          end else begin
            next_r.state = ST_IDLE;
            next_r.ctrl_a[CA_START_BIT] = 1'b0;                 // RULE_11
          end
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
    if (!r.ctrl_a[CA_ENABLE_BIT]) begin
      next_r.state = ST_IDLE;
      next_r.ctrl_a[CA_START_BIT] = 1'b0;
    end

    // Comparator side outputs
    next_r.cmp_irq = next_r.cmp_ctrl[CMP_FLAG_BIT] && next_r.cmp_ctrl[CMP_IE_BIT]
                     && next_r.cpu_status[GIE_BIT];             // RULE_21
    next_r.capture_in = r.cmp_ctrl[CMP_CAPT_BIT] && r.cmp_sync; // RULE_01
    if (r.ctrl_b[CB_MUXEN_BIT] && !r.ctrl_a[CA_ENABLE_BIT])
      next_r.neg_sel = {1'b1, r.mux_sel[2:0]};                  // RULE_04
    else
      next_r.neg_sel = 4'h0;                                    // RULE_04
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack            = r.ack;
  assign wb_dat_o          = r.rdata;
  assign cmp_irq_req       = r.cmp_irq;
  assign capture_route_out = r.capture_in;
  assign cmp_neg_select    = r.neg_sel;
  assign sample_request    = r.sample_req;
  assign active_mux_select = r.mux_active;
  assign conv_done_pulse   = r.conv_pulse;

  // Disabled pins 0 and 1 read zero; pins 2 to 7 ignore their disable bit
  genvar g;
  for (g = 0; g < 8; g++) begin : g_pin
    logic pin_q;
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pin_q <= 1'b0;
      end else begin
        pin_q <= (g < 2 && r.pin_disable[g]) ? 1'b0 : r.port_sync[g]; // RULE_05
      end
    end
    assign port_pins_read[g] = pin_q;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_irq_gating: assert property (@(posedge ref_clk) disable iff (rst)
    cmp_irq_req |-> (r.cmp_ctrl[CMP_IE_BIT] && r.cpu_status[GIE_BIT]))
    else $error("comparator request without enables"); // RULE_21
  a_route_off: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(r.cmp_ctrl[CMP_CAPT_BIT]) |-> !capture_route_out)
    else $error("capture path active while disabled"); // RULE_01
  a_mux_off: assert property (@(posedge ref_clk) disable iff (rst)
    $past(r.ctrl_a[CA_ENABLE_BIT]) |-> cmp_neg_select == 4'h0)
    else $error("channel mux used while converter on"); // RULE_04
  a_pin_zero: assert property (@(posedge ref_clk) disable iff (rst)
    $past(r.pin_disable[0]) |-> !port_pins_read[0])
    else $error("disabled pin read nonzero"); // RULE_05
  a_lock_hold: assert property (@(posedge ref_clk) disable iff (rst)
    r.read_lock && $stable(r.read_lock) |-> $stable(r.result))
    else $error("result changed while locked"); // RULE_09
  a_done_flag: assert property (@(posedge ref_clk) disable iff (rst)
    conv_done_pulse |-> r.ctrl_a[CA_DONE_BIT])
    else $error("done pulse without flag"); // RULE_10
  a_start_busy: assert property (@(posedge ref_clk) disable iff (rst)
    r.state == ST_CONV |-> r.ctrl_a[CA_START_BIT])
    else $error("start bit low during conversion"); // RULE_17
  a_conv_len: assert property (@(posedge ref_clk) disable iff (rst)
    sample_request |=> !conv_done_pulse [*8])
    else $error("conversion ended too early"); // RULE_20
  a_cmp_sync: assert property (@(posedge ref_clk) disable iff (rst)
    r.cmp_ctrl[CMP_OUT_BIT] == $past(r.cmp_meta, 2))
    else $error("comparator status delay wrong"); // RULE_19
  a_mux_pick: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
    $past(r.ctrl_b[CB_MUXEN_BIT] && !r.ctrl_a[CA_ENABLE_BIT])
    |-> cmp_neg_select == {1'b1, $past(r.mux_sel[2:0])})
    else $error("negative input pick wrong");
  a_route_on: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    $past(r.cmp_ctrl[CMP_CAPT_BIT]) |-> capture_route_out == $past(r.cmp_sync))
    else $error("capture path does not follow comparator");
  a_irq_set: assert property (@(posedge ref_clk) disable iff (rst) // RULE_21
    r.cmp_ctrl[CMP_FLAG_BIT] && r.cmp_ctrl[CMP_IE_BIT] && r.cpu_status[GIE_BIT] |-> cmp_irq_req)
    else $error("comparator request missing");
  a_rise_flag: assert property (@(posedge ref_clk) disable iff (rst) // RULE_02
    r.cmp_ctrl[1:0] == CMP_RISING && r.cmp_sync && !r.cmp_prev |=> r.cmp_ctrl[CMP_FLAG_BIT])
    else $error("rising edge did not set flag");
  a_fall_flag: assert property (@(posedge ref_clk) disable iff (rst) // RULE_02
    r.cmp_ctrl[1:0] == CMP_FALLING && !r.cmp_sync && r.cmp_prev |=> r.cmp_ctrl[CMP_FLAG_BIT])
    else $error("falling edge did not set flag");
  a_toggle_flag: assert property (@(posedge ref_clk) disable iff (rst) // RULE_18
    r.cmp_ctrl[1:0] == CMP_TOGGLE && r.cmp_sync != r.cmp_prev |=> r.cmp_ctrl[CMP_FLAG_BIT])
    else $error("toggle did not set flag");
  a_idle_start: assert property (@(posedge ref_clk) disable iff (rst) // RULE_11
    r.state == ST_IDLE |-> !r.ctrl_a[CA_START_BIT])
    else $error("start bit high while idle");
  a_free_restart: assert property (@(posedge ref_clk) disable iff (rst) // RULE_16
    conv_done_pulse && $past(r.ctrl_a[CA_AUTO_BIT])
    && $past(r.ctrl_b[2:0]) == TRIG_FREE_RUN |-> sample_request)
    else $error("free running did not restart");
  a_lock_set: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
    rd && wb_req.adr[5:2] == IDX_RES_LOW |=> r.read_lock)
    else $error("low byte read did not lock");
  a_mux_frozen: assert property (@(posedge ref_clk) disable iff (rst) // RULE_12
    $past(r.state == ST_CONV && !conv_end) |-> $stable(active_mux_select))
    else $error("selection changed mid-conversion");
  a_mux_gated: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
    !$past(r.ctrl_a[CA_ENABLE_BIT]) |-> $stable(active_mux_select))
    else $error("selection applied while disabled");
  a_prescale_rst: assert property (@(posedge ref_clk) disable iff (rst) // RULE_13
    r.state == ST_IDLE && r.ctrl_a[CA_ENABLE_BIT] && r.ctrl_a[CA_AUTO_BIT]
    && trig_edge && !start_req |=> r.prescale == 3'h0)
    else $error("trigger did not reset prescaler");
  a_left_high: assert property (@(posedge ref_clk) disable iff (rst) // RULE_22
    rd && wb_req.adr[5:2] == IDX_RES_HIGH && r.mux_sel[MX_LEFT_BIT]
    |=> wb_dat_o[7:0] == $past(r.result[9:2]))
    else $error("left aligned high byte wrong");
  a_right_high: assert property (@(posedge ref_clk) disable iff (rst) // RULE_08
    rd && wb_req.adr[5:2] == IDX_RES_HIGH && !r.mux_sel[MX_LEFT_BIT]
    |=> wb_dat_o[7:0] == {6'h00, $past(r.result[9:8])})
    else $error("right aligned high byte wrong");

endmodule

// ### dv/testbench.sv
/*
  Self-checking bench for the converter control block: register access,
  comparator events, pin gating, negative-input mux, conversions, result
  lock, auto trigger and free running.
  Assumes conv_pkg is compiled first and that the design carries its own
  assertions.
*/
`timescale 1ns/1ps

module testbench;
  import conv_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        ref_clk           = 1'b0;
  logic        rst               = 1'b1;
  wb_req_t     wb_req            = '0;
  logic        wb_ack;
  logic [31:0] wb_dat_o;
  logic        cmp_raw_out       = 1'b0;
  logic [7:0]  port_pins_in      = 8'h00;
  logic [7:0]  port_pins_read;
  logic        capture_route_out;
  logic [3:0]  cmp_neg_select;
  logic        cmp_irq_req;
  logic        cmp_vector_taken  = 1'b0;
  logic [9:0]  analog_code       = 10'h000;
  logic [7:0]  trigger_sources   = 8'h00;
  logic        sample_request;
  logic [7:0]  active_mux_select;
  logic        conv_done_pulse;
  int          errors            = 0;
  int          samples_checked   = 0;
  int          cycles            = 0;
  logic [7:0]  rd;
  logic        seen;

  analog_conversion_control i_analog_conversion_control (
    .ref_clk(ref_clk), .rst(rst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
    .cmp_raw_out(cmp_raw_out), .port_pins_in(port_pins_in), .port_pins_read(port_pins_read),
    .capture_route_out(capture_route_out), .cmp_neg_select(cmp_neg_select),
    .cmp_irq_req(cmp_irq_req), .cmp_vector_taken(cmp_vector_taken),
    .analog_code(analog_code), .trigger_sources(trigger_sources),
    .sample_request(sample_request), .active_mux_select(active_mux_select),
    .conv_done_pulse(conv_done_pulse)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; ack and data are taken at the edge
  task automatic wb_cycle(input logic w, input logic [3:0] idx, input logic [7:0] wd);
    wb_req.cyc <= 1'b1;
    wb_req.stb <= 1'b1;
    wb_req.we  <= w;
    wb_req.adr <= {idx, 2'b00};
    wb_req.sel <= 4'h1;
    wb_req.dat <= {24'h000000, wd};
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    wb_cycle(1'b1, idx, d);
  endtask

  task automatic rdr(input logic [3:0] idx);
    wb_cycle(1'b0, idx, 8'h00);
  endtask

  task automatic poll(ref logic s, input int lim);
    seen = 1'b0;
    for (int i = 0; i < lim; i++) begin
      @(posedge ref_clk);
      if (s === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rdr(i[3:0]);
      check_byte(rd, REG_RESET);
    end
    wr(4'hf, 8'hff);
    rdr(4'hf);
    check_byte(rd, 8'h00);
  endtask

  // Mode written with the enable clear, flag cleared, then enabled
  task automatic cmp_event(input logic [1:0] mode, input logic lvl, input logic exp,
                           input logic flg);
    wr(IDX_CMP_CTRL, {6'h00, mode});
    wr(IDX_CMP_CTRL, 8'h10 | {6'h00, mode});
    wr(IDX_CMP_CTRL, 8'h08 | {6'h00, mode});
    cmp_raw_out <= lvl;
    poll(cmp_irq_req, 10);
    check_bit(seen, exp);
    rdr(IDX_CMP_CTRL);
    check_bit(rd[CMP_OUT_BIT], lvl);
    check_bit(rd[CMP_FLAG_BIT], flg);
    cmp_vector_taken <= 1'b1;
    @(posedge ref_clk);
    cmp_vector_taken <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check_bit(cmp_irq_req, 1'b0);
  endtask

  task automatic t_cmp();
    wr(IDX_CPU_STATUS, 8'h80);
    cmp_event(CMP_RISING, 1'b1, 1'b1, 1'b1);
    cmp_event(CMP_FALLING, 1'b0, 1'b1, 1'b1);
    cmp_event(CMP_TOGGLE, 1'b1, 1'b1, 1'b1);
    cmp_event(CMP_RISING, 1'b0, 1'b0, 1'b0);
    cmp_event(CMP_RESVD, 1'b1, 1'b0, 1'b0);
    wr(IDX_CPU_STATUS, 8'h00);
    cmp_event(CMP_TOGGLE, 1'b0, 1'b0, 1'b1);
    cmp_raw_out <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rdr(IDX_CMP_CTRL);
    check_bit(rd[CMP_FLAG_BIT], 1'b1);
    wr(IDX_CMP_CTRL, 8'h10);
    rdr(IDX_CMP_CTRL);
    check_bit(rd[CMP_FLAG_BIT], 1'b0);
  endtask

  task automatic t_pins();
    port_pins_in <= 8'ha7;
    wr(IDX_PIN_DISABLE, 8'h03);
    repeat (4) @(posedge ref_clk);
    check_byte(port_pins_read, 8'ha4);
    wr(IDX_PIN_DISABLE, 8'h00);
    repeat (4) @(posedge ref_clk);
    check_byte(port_pins_read, 8'ha7);
    wr(IDX_CMP_CTRL, 8'h04);
    repeat (4) @(posedge ref_clk);
    check_bit(capture_route_out, 1'b1);
    wr(IDX_CMP_CTRL, 8'h00);
    repeat (4) @(posedge ref_clk);
    check_bit(capture_route_out, 1'b0);
  endtask

  task automatic t_neg();
    wr(IDX_CTRL_B, 8'h40);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_MUX_SEL, {5'h00, c[2:0]});
      repeat (2) @(posedge ref_clk);
      check_byte({4'h0, cmp_neg_select}, {4'h0, 1'b1, c[2:0]});
    end
    wr(IDX_CTRL_A, 8'h80);
    repeat (2) @(posedge ref_clk);
    check_byte({4'h0, cmp_neg_select}, 8'h00);
    wr(IDX_CTRL_A, 8'h00);
    wr(IDX_CTRL_B, 8'h00);
    repeat (2) @(posedge ref_clk);
    check_byte({4'h0, cmp_neg_select}, 8'h00);
  endtask

  task automatic conv(input logic [7:0] ctl);
    wr(IDX_CTRL_A, ctl);
    poll(conv_done_pulse, 400);
    check_bit(seen, 1'b1);
  endtask

  task automatic t_conv();
    analog_code <= 10'h2b6;
    wr(IDX_MUX_SEL, 8'h02);
    repeat (2) @(posedge ref_clk);
    check_byte({5'h00, active_mux_select[2:0]}, 8'h07);
    wr(IDX_CTRL_A, 8'h80);
    repeat (2) @(posedge ref_clk);
    check_byte({5'h00, active_mux_select[2:0]}, 8'h02);
    wr(IDX_CTRL_A, 8'hc0);
    rdr(IDX_CTRL_A);
    check_bit(rd[CA_START_BIT], 1'b1);
    wr(IDX_MUX_SEL, 8'h03);
    repeat (2) @(posedge ref_clk);
    check_byte({5'h00, active_mux_select[2:0]}, 8'h02);
    poll(conv_done_pulse, 400);
    check_bit(seen, 1'b1);
    repeat (3) @(posedge ref_clk);
    check_byte({5'h00, active_mux_select[2:0]}, 8'h03);
    rdr(IDX_CTRL_A);
    check_bit(rd[CA_START_BIT], 1'b0);
    check_bit(rd[CA_DONE_BIT], 1'b1);
    rdr(IDX_RES_LOW);
    check_byte(rd, 8'hb6);
    rdr(IDX_RES_HIGH);
    check_byte(rd, 8'h02);
  endtask

  task automatic t_lock();
    analog_code <= 10'h1c9;
    wr(IDX_MUX_SEL, 8'h23);
    conv(8'hd0);
    rdr(IDX_RES_LOW);
    check_byte(rd, 8'h40);
    analog_code <= 10'h3ff;
    conv(8'hd0);
    rdr(IDX_CTRL_A);
    check_bit(rd[CA_DONE_BIT], 1'b1);
    rdr(IDX_RES_HIGH);
    check_byte(rd, 8'h72);
    rdr(IDX_RES_LOW);
    check_byte(rd, 8'h40);
    rdr(IDX_RES_HIGH);
    check_byte(rd, 8'h72);
  endtask

  task automatic t_auto();
    wr(IDX_CTRL_B, 8'h01);
    wr(IDX_CTRL_A, 8'hb0);
    trigger_sources <= 8'h02;
    poll(sample_request, 20);
    check_bit(seen, 1'b1);
    rdr(IDX_CTRL_A);
    check_bit(rd[CA_START_BIT], 1'b1);
    poll(conv_done_pulse, 400);
    poll(sample_request, 150);
    check_bit(seen, 1'b0);
    conv(8'hf0);
    trigger_sources <= 8'h00;
    wr(IDX_CTRL_B, 8'h00);
    conv(8'he0);
    poll(conv_done_pulse, 400);
    check_bit(seen, 1'b1);
    wr(IDX_CTRL_A, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_cmp();
    t_pins();
    t_neg();
    t_conv();
    t_lock();
    t_auto();
    complete_run();
  end
endmodule
